//--- link_device.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "link_cfg.svh"
// How it works
// - code 0x81: mode 8, one lane
// - code 0x82: mode 8, two lanes
// - code 0x91: mode 9, one lane
// - codes C1/C2/C4: mode C, lanes 0/1/3
// - codes D1/D2: mode D, lanes 0/1
// - codes E1/E2/E4: mode E, lanes 0/1/3
// - presets write 0xF to both parameter registers
// - undefined codes change nothing
// - tail bits zero when random fill off
// - tail bits from 31-bit LFSR when on
// - test samples replace converter data
// - no lane sync: only K28.7 alignment
// - lane sync: K28.3 or K28.7 alignment
// - software keeps insertion on with lane sync
// - alignment mode 00 off, 01 on, 10 reserved
// - alignment mode 11 repeats sequence continuously
// - bit 1 set disables character insertion
// - power-down holds link in reset, clock off
// - sync request drives K28.5 characters
// - software powers down before reconfiguring
// - control register one resets to 0x14
// - quick setup register reads back zero
module link_device #(
  parameter int TAIL_BITS = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  link_if.device port,
  input wire logic [15:0] sampleIn,
  input wire logic endOfFrame,
  input wire logic endOfMultiframe,
  output logic [TAIL_BITS-1:0] tailBits,
  output logic [15:0] sampleOut,
  output logic [7:0] controlChar,
  output logic controlCharValid,
  output logic linkReset,
  output logic linkClockEnable,
  output logic ilasActive,
  output logic ilasContinuous,
  output logic [3:0] decimationMode,
  output logic [4:0] laneCount
);
  import link_pkg::*;

  initial begin
    if (TAIL_BITS < 1 || TAIL_BITS > 16) $error("TAIL_BITS out of range");
  end

  typedef struct packed {
    logic [7:0] ctrl;
    logic [3:0] ddcMode;
    logic [4:0] lanes;
    logic [4:0] paramA;
    logic [4:0] paramB;
    logic [30:0] lfsr;
    logic [1:0] sync0;
    logic [1:0] sync1;
    logic ilasDone;
    logic [7:0] rdata;
    logic rvalid;
    logic [TAIL_BITS-1:0] tail;
    logic [15:0] sample;
    logic [7:0] kchar;
    logic kvalid;
    logic [15:0] testCount;
  } dev_state_t;

  dev_state_t cur;
  dev_state_t next_cur;
  logic syncReq;
  logic [30:0] stepped;
  ilas_t ilasMode;

  // ---------------------------------------------------------------
  // control and link logic
  // ---------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    syncReq = ~cur.sync1[1];
    ilasMode = ilas_t'(cur.ctrl[`BIT_ILAS_HI:`BIT_ILAS_LO]);
    stepped = cur.lfsr;
    next_cur.sync0 = {cur.sync0[0], port.syncRequestN};
    next_cur.sync1 = {cur.sync1[0], cur.sync0[1]};
    next_cur.rvalid = port.rdEn;
    next_cur.rdata = 8'h00;
    if (port.rdEn) begin
      case (port.addr)
        `QUICK_SETUP_ADDR: next_cur.rdata = 8'h00;
        `LINK_CTRL1_ADDR: next_cur.rdata = cur.ctrl;
        `DDC_MODE_ADDR: next_cur.rdata = {4'h0, cur.ddcMode};
        `LANE_COUNT_ADDR: next_cur.rdata = {3'h0, cur.lanes};
        `LINK_PARAM_A_ADDR: next_cur.rdata = {3'h0, cur.paramA};
        `LINK_PARAM_B_ADDR: next_cur.rdata = {3'h0, cur.paramB};
        default: next_cur.rdata = 8'h00;
      endcase
    end
    if (port.wrEn) begin
      case (port.addr)
        `LINK_CTRL1_ADDR: next_cur.ctrl = port.wdata & `CTRL1_WRITE_MASK;
        `DDC_MODE_ADDR: next_cur.ddcMode = port.wdata[3:0];
        `LANE_COUNT_ADDR: next_cur.lanes = port.wdata[4:0];
        `LINK_PARAM_A_ADDR: next_cur.paramA = port.wdata[4:0];
        `LINK_PARAM_B_ADDR: next_cur.paramB = port.wdata[4:0];
        `QUICK_SETUP_ADDR: begin
          case (port.wdata)
            8'h81, 8'h82, 8'h91, 8'hc1, 8'hc2, 8'hc4, 8'hd1, 8'hd2, 8'he1, 8'he2, 8'he4: begin
              next_cur.ddcMode = port.wdata[7:4] == 4'h8 ? 4'h8 : port.wdata[7:4];
              case (port.wdata[3:0])
                4'h1: next_cur.lanes = 5'h00;
                4'h2: next_cur.lanes = 5'h01;
                4'h4: next_cur.lanes = 5'h03;
                default: next_cur.lanes = cur.lanes;
              endcase
              next_cur.paramA = `PRESET_PARAM;
              next_cur.paramB = `PRESET_PARAM;
            end
            default: next_cur = next_cur;
          endcase
        end
        default: next_cur = next_cur;
      endcase
    end
    // link datapath, held in reset while powered down
    if (cur.ctrl[`BIT_POWER_DOWN]) begin
      next_cur.lfsr = `LFSR_SEED;
      next_cur.ilasDone = 1'b0;
      next_cur.tail = '0;
      next_cur.sample = 16'h0000;
      next_cur.kchar = 8'h00;
      next_cur.kvalid = 1'b0;
      next_cur.testCount = 16'h0000;
    end else begin
      for (int i = 0; i < TAIL_BITS; i++) begin
        stepped = {stepped[29:0], stepped[30] ^ stepped[27]};
      end
      next_cur.lfsr = stepped;
      next_cur.tail = cur.ctrl[`BIT_TAIL_PRN] ? stepped[TAIL_BITS-1:0] : '0;
      next_cur.testCount = cur.testCount + 16'h0001;
      next_cur.sample = cur.ctrl[`BIT_TEST_SAMPLE] ? cur.testCount : sampleIn;
      next_cur.kvalid = 1'b0;
      next_cur.kchar = 8'h00;
      if (syncReq) begin
        next_cur.kchar = `K28_5;
        next_cur.kvalid = 1'b1;
        next_cur.ilasDone = 1'b0;
      end else begin
        if (endOfMultiframe) next_cur.ilasDone = 1'b1;
        if (!cur.ctrl[`BIT_FRAME_ALIGN_CHAR_INSERT_OFF] && endOfFrame) begin
          next_cur.kvalid = 1'b1;
          next_cur.kchar = `K28_7;
          if (cur.ctrl[`BIT_LANE_SYNC] && endOfMultiframe) next_cur.kchar = `K28_3;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur <= '0;
      cur.ctrl <= `LINK_CTRL1_RESET;
      cur.lfsr <= `LFSR_SEED;
      cur.sync0 <= 2'h3;
      cur.sync1 <= 2'h3;
    end else if (clkEn) begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign port.rdata = cur.rdata;
  assign port.rvalid = cur.rvalid;
  assign tailBits = cur.tail;
  assign sampleOut = cur.sample;
  assign controlChar = cur.kchar;
  assign controlCharValid = cur.kvalid;
  assign linkReset = cur.ctrl[`BIT_POWER_DOWN];
  assign linkClockEnable = ~cur.ctrl[`BIT_POWER_DOWN];
  assign ilasActive = !cur.ctrl[`BIT_POWER_DOWN] && (ilasMode == ILAS_CONTINUOUS ||
    (ilasMode == ILAS_ENABLED && !cur.ilasDone && !syncReq));
  assign ilasContinuous = ilasMode == ILAS_CONTINUOUS;
  assign decimationMode = cur.ddcMode;
  assign laneCount = cur.lanes;
endmodule

//--- link_cfg.svh
`ifndef LINK_CFG_SVH
`define LINK_CFG_SVH
`define QUICK_SETUP_ADDR 8'h5e
`define LINK_CTRL1_ADDR 8'h5f
`define DDC_MODE_ADDR 8'h63
`define LANE_COUNT_ADDR 8'h6e
`define LINK_PARAM_A_ADDR 8'h72
`define LINK_PARAM_B_ADDR 8'h73
`define LINK_CTRL1_RESET 8'h14
`define DDC_MODE_RESET 4'h0
`define LINK_PARAM_RESET 5'h00
`define PRESET_PARAM 5'h0f
`define BIT_TAIL_PRN 6
`define BIT_TEST_SAMPLE 5
`define BIT_LANE_SYNC 4
`define BIT_ILAS_HI 3
`define BIT_ILAS_LO 2
`define BIT_FRAME_ALIGN_CHAR_INSERT_OFF 1
`define BIT_POWER_DOWN 0
`define CTRL1_WRITE_MASK 8'h7f
`define K28_3 8'h7c
`define K28_5 8'hbc
`define K28_7 8'hfc
`define LFSR_SEED 31'h7fffffff
`define ILAS_OFF 2'h0
`define ILAS_ON 2'h1
`define ILAS_REPEAT 2'h3
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`define HOST_CMD_OFFSET 4'h0
`define HOST_STATUS_OFFSET 4'h4
`define HOST_RDATA_OFFSET 4'h8
`endif

//--- link_pkg.sv
package link_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {ILAS_DISABLED, ILAS_ENABLED, ILAS_RESERVED, ILAS_CONTINUOUS} ilas_t;
  typedef enum {H_IDLE, H_WRITE, H_READ, H_WAIT} host_state_t;
endpackage

//--- link_if.sv
`timescale 1ns/1ps
interface link_if;
  logic wrEn;
  logic rdEn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic syncRequestN;
  modport device (input wrEn, input rdEn, input addr, input wdata, output rdata, output rvalid,
    input syncRequestN);
  modport host (output wrEn, output rdEn, output addr, output wdata, input rdata,
    input rvalid, output syncRequestN);
endinterface

//--- link_host.sv
`timescale 1ns/1ps
`include "link_cfg.svh"
module link_host (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  link_if.host port,
  input wire logic syncRequestIn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import link_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic haveAw;
    logic haveW;
    logic [3:0] wOff;
    logic [17:0] cmd;
    logic busy;
    logic [7:0] lastRead;
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wd;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } host_state_s_t;

  host_state_s_t cur;
  host_state_s_t next_cur;

  // ---------------------------------------------------------------
  // axi slave and device access
  // ---------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.wrEn = 1'b0;
    next_cur.rdEn = 1'b0;
    awready = !cur.haveAw && !cur.bv;
    wready = !cur.haveW && !cur.bv;
    arready = !cur.rv;
    if (awvalid && awready) begin
      next_cur.haveAw = 1'b1;
      next_cur.wOff = awaddr[3:0];
    end
    if (wvalid && wready && wstrb[0]) next_cur.cmd = wdata[17:0];
    if (wvalid && wready) next_cur.haveW = 1'b1;
    if (cur.haveAw && cur.haveW) begin
      next_cur.haveAw = 1'b0;
      next_cur.haveW = 1'b0;
      next_cur.bv = 1'b1;
      next_cur.br = cur.wOff == `HOST_CMD_OFFSET && !cur.busy ? `AXI_OKAY : `AXI_SLVERR;
      if (cur.wOff == `HOST_CMD_OFFSET && !cur.busy) begin
        next_cur.busy = 1'b1;
        next_cur.addr = cur.cmd[15:8];
        next_cur.wd = cur.cmd[7:0];
        next_cur.wrEn = cur.cmd[16];
        next_cur.rdEn = cur.cmd[17];
      end
    end
    if (cur.bv && bready) next_cur.bv = 1'b0;
    if (cur.busy && !cur.rdEn && !cur.wrEn && (!cur.cmd[17] || port.rvalid)) next_cur.busy = 1'b0;
    if (port.rvalid) next_cur.lastRead = port.rdata;
    if (arvalid && arready) begin
      next_cur.rv = 1'b1;
      next_cur.rr = `AXI_OKAY;
      case (araddr[3:0])
        `HOST_CMD_OFFSET: next_cur.rd = {14'h0000, cur.cmd};
        `HOST_STATUS_OFFSET: next_cur.rd = {31'h00000000, cur.busy};
        `HOST_RDATA_OFFSET: next_cur.rd = {24'h000000, cur.lastRead};
        default: begin
          next_cur.rd = 32'h00000000;
          next_cur.rr = `AXI_SLVERR;
        end
      endcase
    end
    if (cur.rv && rready) next_cur.rv = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) cur <= '0;
    else if (clkEn) cur <= next_cur;
  end

  assign port.wrEn = cur.wrEn;
  assign port.rdEn = cur.rdEn;
  assign port.addr = cur.addr;
  assign port.wdata = cur.wd;
  assign port.syncRequestN = ~syncRequestIn;
  assign bvalid = cur.bv;
  assign bresp = cur.br;
  assign rvalid = cur.rv;
  assign rdata = cur.rd;
  assign rresp = cur.rr;
endmodule

//--- link_properties.sv
`timescale 1ns/1ps
`include "link_cfg.svh"
module link_properties (
  input logic clk_sys,
  input logic rst,
  input logic wrEn,
  input logic rdEn,
  input logic [7:0] addr,
  input logic [7:0] wdata,
  input logic [7:0] rdata,
  input logic rvalid,
  input logic syncRequestN
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [3:0] mode;
    logic [4:0] lanes;
    logic [4:0] parA;
    logic [4:0] parB;
  } shadow_t;
  shadow_t shadow;
  shadow_t next_shadow;

  // ----------------------------------------
  // expected register contents
  // ----------------------------------------
  always_comb begin
    next_shadow = shadow;
    if (wrEn) begin
      case (addr)
        `LINK_CTRL1_ADDR: next_shadow.ctrl = wdata & `CTRL1_WRITE_MASK;
        `DDC_MODE_ADDR: next_shadow.mode = wdata[3:0];
        `LANE_COUNT_ADDR: next_shadow.lanes = wdata[4:0];
        `LINK_PARAM_A_ADDR: next_shadow.parA = wdata[4:0];
        `LINK_PARAM_B_ADDR: next_shadow.parB = wdata[4:0];
        `QUICK_SETUP_ADDR: begin
          if (wdata inside {8'h81, 8'h82, 8'h91, 8'hc1, 8'hc2, 8'hc4, 8'hd1, 8'hd2,
              8'he1, 8'he2, 8'he4}) begin
            next_shadow.mode = wdata[7:4];
            next_shadow.lanes = {1'b0, wdata[3:0] - 4'h1};
            next_shadow.parA = `PRESET_PARAM;
            next_shadow.parB = `PRESET_PARAM;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shadow <= {`LINK_CTRL1_RESET, `DDC_MODE_RESET, 5'h00, `LINK_PARAM_RESET, `LINK_PARAM_RESET};
    end else begin
      shadow <= next_shadow;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  read_answer_a: assert property (rdEn |=> rvalid)
    else $error("read not answered one cycle later");
  answer_cause_a: assert property (rvalid |-> $past(rdEn))
    else $error("read answer without a read");
  quick_clear_a: assert property (rdEn && addr == `QUICK_SETUP_ADDR |=> rdata == 8'h00)
    else $error("quick setup register not clear");
  ctrl_read_a: assert property (rdEn && addr == `LINK_CTRL1_ADDR |=> rdata == $past(shadow.ctrl))
    else $error("control register one read mismatch");
  mode_read_a: assert property (rdEn && addr == `DDC_MODE_ADDR |=> rdata == {4'h0, $past(shadow.mode)})
    else $error("decimation mode read mismatch");
  lanes_read_a: assert property (rdEn && addr == `LANE_COUNT_ADDR |=> rdata == {3'h0, $past(shadow.lanes)})
    else $error("lane count read mismatch");
  param_a_read_a: assert property (rdEn && addr == `LINK_PARAM_A_ADDR |=> rdata[4:0] == $past(shadow.parA))
    else $error("first link parameter read mismatch");
  param_b_read_a: assert property (rdEn && addr == `LINK_PARAM_B_ADDR |=> rdata[4:0] == $past(shadow.parB))
    else $error("second link parameter read mismatch");
  unmapped_read_a: assert property (rdEn && !(addr inside {8'h5e, 8'h5f, 8'h63, 8'h6e, 8'h72, 8'h73})
      |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

//--- serial_link_quick_config_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "link_cfg.svh"
`define CHECK(got, want) begin total_checks++; if ((got) !== (want)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, got, want); end end
module serial_link_quick_config_ctrl_tb_top;
  import link_pkg::*;
  logic clk_sys = 0, rst = 1, clkEn = 1, syncRequestIn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, tailBits;
  logic [15:0] sampleIn = 0;
  logic [15:0] sampleOut;
  logic endOfFrame = 0, endOfMultiframe = 0;
  logic [7:0] controlChar;
  logic controlCharValid, linkReset, linkClockEnable, ilasActive, ilasContinuous;
  logic [3:0] decimationMode;
  logic [4:0] laneCount;
  int failures = 0, total_checks = 0;
  byte_t presets[11] = '{8'h81, 8'h82, 8'h91, 8'hc1, 8'hc2, 8'hc4, 8'hd1, 8'hd2, 8'he1, 8'he2, 8'he4};
  link_if lnk();
  link_host link_host_i (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .port(lnk.host),
    .syncRequestIn(syncRequestIn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  link_device link_device_i (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .port(lnk.device),
    .sampleIn(sampleIn), .endOfFrame(endOfFrame), .endOfMultiframe(endOfMultiframe),
    .tailBits(tailBits), .sampleOut(sampleOut), .controlChar(controlChar),
    .controlCharValid(controlCharValid), .linkReset(linkReset),
    .linkClockEnable(linkClockEnable), .ilasActive(ilasActive), .ilasContinuous(ilasContinuous),
    .decimationMode(decimationMode), .laneCount(laneCount));
  link_properties link_properties_i (.clk_sys(clk_sys), .rst(rst), .wrEn(lnk.wrEn),
    .rdEn(lnk.rdEn), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
    .rvalid(lnk.rvalid), .syncRequestN(lnk.syncRequestN));

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    sampleIn <= 16'($urandom);
    endOfFrame <= 1'($urandom);
    endOfMultiframe <= 1'($urandom);
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (awvalid && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    while (!bvalid) @(posedge clk_sys);
    bready <= 0;
    `CHECK(bresp, `AXI_OKAY)
  endtask

  task automatic axiRead(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge clk_sys);
    d = rdata;
    rready <= 0;
  endtask

  task automatic devAccess(input logic [1:0] op, input byte_t a, input byte_t d, output byte_t r);
    logic [31:0] s;
    axiWrite(32'(`HOST_CMD_OFFSET), {14'h0, op, a, d});
    do axiRead(32'(`HOST_STATUS_OFFSET), s); while (s[0] !== 1'b0);
    axiRead(32'(`HOST_RDATA_OFFSET), s);
    r = s[7:0];
  endtask

  task automatic devWrite(input byte_t a, input byte_t d);
    byte_t r;
    devAccess(2'b01, a, d, r);
  endtask

  task automatic expectReg(input byte_t a, input byte_t want);
    byte_t r;
    devAccess(2'b10, a, 8'h00, r);
    `CHECK(r, want)
  endtask

  // powers down, loads a control value, then watches the link for 32 cycles
  task automatic watchLink(input byte_t c);
    logic [15:0] prev;
    logic [1:0] tailAny;
    int kSeen;
    devWrite(`LINK_CTRL1_ADDR, c | 8'h01);
    devWrite(`LINK_CTRL1_ADDR, c);
    tailAny = 2'b00;
    kSeen = 0;
    @(posedge clk_sys);
    prev = sampleOut;
    repeat (32) begin
      @(posedge clk_sys);
      tailAny = tailAny | tailBits;
      if (c[`BIT_TEST_SAMPLE]) `CHECK(sampleOut, 16'(prev + 16'h0001))
      prev = sampleOut;
      if (controlCharValid === 1'b1) begin
        kSeen++;
        if (c[`BIT_LANE_SYNC] && controlChar == `K28_3) `CHECK(controlChar, `K28_3)
        else `CHECK(controlChar, `K28_7)
      end
    end
    `CHECK(tailAny != 2'b00, c[`BIT_TAIL_PRN])
    `CHECK(kSeen != 0, !c[`BIT_FRAME_ALIGN_CHAR_INSERT_OFF])
  endtask

  task automatic test_done;
    $display("Checks made %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    failures++;
    test_done();
  end

  initial begin
    byte_t code;
    logic [15:0] held;
    void'($urandom(83199));
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    expectReg(`LINK_CTRL1_ADDR, `LINK_CTRL1_RESET);
    expectReg(`DDC_MODE_ADDR, 8'h00);
    expectReg(`LANE_COUNT_ADDR, 8'h00);
    expectReg(8'h10, 8'h00);
    syncRequestIn <= 1;
    repeat (6) @(posedge clk_sys);
    `CHECK({controlCharValid, controlChar}, {1'b1, 8'(`K28_5)})
    `CHECK(tailBits, 2'b00)
    syncRequestIn <= 0;
    devWrite(`LINK_CTRL1_ADDR, 8'h15);
    `CHECK({linkReset, linkClockEnable}, 2'b10)
    devWrite(`LINK_CTRL1_ADDR, 8'hfd);
    `CHECK(ilasContinuous, 1'b1)
    expectReg(`LINK_CTRL1_ADDR, 8'h7d);
    devWrite(`LINK_CTRL1_ADDR, 8'h11);
    `CHECK(ilasActive, 1'b0)
    watchLink(8'h50);
    watchLink(8'h00);
    watchLink(8'h22);
    clkEn <= 0;
    @(posedge clk_sys);
    @(posedge clk_sys);
    held = sampleOut;
    repeat (8) @(posedge clk_sys);
    `CHECK(sampleOut, held)
    clkEn <= 1;
    devWrite(`LINK_CTRL1_ADDR, 8'h15);
    devWrite(`LINK_CTRL1_ADDR, 8'h14);
    foreach (presets[i]) begin
      devWrite(`DDC_MODE_ADDR, 8'($urandom));
      devWrite(`LINK_PARAM_A_ADDR, 8'($urandom));
      devWrite(`QUICK_SETUP_ADDR, presets[i]);
      `CHECK(decimationMode, presets[i][7:4])
      `CHECK(laneCount, {1'b0, presets[i][3:0] - 4'h1})
      expectReg(`QUICK_SETUP_ADDR, 8'h00);
      expectReg(`LINK_PARAM_A_ADDR, 8'h0f);
    end
    for (int i = 0; i < 8; i++) begin
      code = (i == 0) ? 8'h48 : 8'($urandom);
      if (code inside {presets})
        code = 8'h01;
      devWrite(`QUICK_SETUP_ADDR, code);
      `CHECK({decimationMode, laneCount}, {4'he, 5'h03})
      expectReg(`LINK_PARAM_B_ADDR, 8'h0f);
    end
    test_done();
  end
endmodule
